// >>> logic/gpaf_params.svh
// Constants and register addresses for the pin function and wake input block.
// Assumes the register decoder above it presents byte-wide writes and reads.
`ifndef GPAF_PARAMS_SVH
`define GPAF_PARAMS_SVH
// ****************************************
// Register addresses
// ****************************************
`define GPAF_ADDR_DIR_MSB   8'h89
`define GPAF_ADDR_DIR_CSB   8'h8A
`define GPAF_ADDR_DIR_LSB   8'h8B
`define GPAF_ADDR_EDGE_MSB  8'h8C
`define GPAF_ADDR_EDGE_CSB  8'h8D
`define GPAF_ADDR_EDGE_LSB  8'h8E
`define GPAF_ADDR_RISE_MSB  8'h8F
`define GPAF_ADDR_RISE_CSB  8'h90
`define GPAF_ADDR_RISE_LSB  8'h91
`define GPAF_ADDR_FALL_MSB  8'h92
`define GPAF_ADDR_FALL_CSB  8'h93
`define GPAF_ADDR_FALL_LSB  8'h94
`define GPAF_ADDR_FU_HIGH   8'h9B
`define GPAF_ADDR_FU_MID    8'h9C
`define GPAF_ADDR_FU_LOW    8'h9D
`define GPAF_ADDR_FL_HIGH   8'h9E
`define GPAF_ADDR_FL_MID    8'h9F
`define GPAF_ADDR_FL_LOW    8'hA0
// ****************************************
// Codes, resets and timing
// ****************************************
`define GPAF_CODE_PRIMARY   2'h0
`define GPAF_CODE_ALT1      2'h1
`define GPAF_CODE_ALT2      2'h2
`define GPAF_CODE_ALT3      2'h3
`define GPAF_RESET_BYTE     8'h00
`define GPAF_RESET_PINS     24'h000000
`define GPAF_CLK_MHZ        40
`define GPAF_PULSE_NS       250
`define GPAF_PULSE_CYCLES   ((`GPAF_PULSE_NS * `GPAF_CLK_MHZ) / 1000)
`define GPAF_MIN_WAKE_NS    62500
`endif

// >>> logic/gpaf_pkg.sv
// Types shared by the pin function block.
// Assumes the params header is included by its users.
package gpaf_pkg;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} gpaf_bus_t;
	typedef enum logic [1:0] {
		GPAF_PRIMARY,
		GPAF_ALT1,
		GPAF_ALT2,
		GPAF_ALT3
	} gpaf_func_t;
	typedef enum {
		GPAF_RUN,
		GPAF_SLEEP
	} gpaf_mode_t;
endpackage : gpaf_pkg

// >>> logic/gpaf_sync.sv
// Three-stage input synchroniser for pins.
// Assumes inputs are asynchronous to CLK; change accepted when stages two and three agree.
`timescale 1ns/1ps
module gpaf_sync #(
	parameter int WIDTH = 24
) (
	input  wire logic             CLK,
	input  wire logic             RST,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_sync_out = sync_out;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2[i] == s3[i]) begin
				next_sync_out[i] = s3[i];
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			s1       <= '0;
			s2       <= '0;
			s3       <= '0;
			sync_out <= '0;
		end else begin
			s1       <= async_in;
			s2       <= s1;
			s3       <= s2;
			sync_out <= next_sync_out;
		end
	end
endmodule : gpaf_sync

// >>> logic/gpaf_hotkey.sv
// Pin function select, direction, edge detection and wake logic for a 24-pin expander.
// Assumes an I2C slave decoder delivers byte writes and reads; CLK runs in both modes.
`include "gpaf_params.svh"
`timescale 1ns/1ps
module gpaf_hotkey #(
	parameter int NPINS = 24
) (
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire gpaf_pkg::gpaf_bus_t    BUS,
	output logic      [7:0]             RDATA,
	input  wire logic                   GLOBAL_INT_EN,
	input  wire logic [NPINS-1:0]       PIN_INT_EN,
	input  wire logic                   INT_EDGE_MODE,
	input  wire logic                   SLEEP_REQ,
	input  wire logic [NPINS-1:0]       PIN_IN,
	input  wire logic [NPINS-1:0]       GPIO_OUT_VAL,
	input  wire logic [NPINS-1:0]       ALT1_OUT,
	input  wire logic [NPINS-1:0]       ALT2_OUT,
	input  wire logic [NPINS-1:0]       ALT3_OUT,
	input  wire logic [NPINS-1:0]       PRIM_OUT,
	output logic      [NPINS-1:0]       PIN_OUT,
	output logic      [NPINS-1:0]       PIN_OE,
	output logic      [NPINS-1:0]       GPIO_IN_VAL,
	output logic      [2*NPINS-1:0]     PIN_FUNC,
	output logic      [NPINS-1:0]       EDGE_FLAGS,
	output logic                        ASLEEP,
	output logic                        WAKE,
	output logic                        INT_REQ
);
	localparam int PW = (`GPAF_PULSE_CYCLES < 1) ? 1 : `GPAF_PULSE_CYCLES;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] sel);
		logic [7:0] r;
		r = v[7:0];
		case (sel)
			2'h2:    r = v[23:16];
			2'h1:    r = v[15:8];
			default: r = v[7:0];
		endcase
		return r;
	endfunction : get_byte

	function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] sel,
						 input logic [7:0] b);
		logic [23:0] r;
		r = v;
		case (sel)
			2'h2:    r[23:16] = b;
			2'h1:    r[15:8]  = b;
			default: r[7:0]   = b;
		endcase
		return r;
	endfunction : put_byte

	// ****************************************
	// Registers
	// ****************************************
	logic [23:0] func_upper;
	logic [23:0] func_lower;
	logic [23:0] pin_direction;
	logic [23:0] rising_edge_enable;
	logic [23:0] falling_edge_enable;
	logic [23:0] edge_detect_flags;
	logic [23:0] next_func_upper;
	logic [23:0] next_func_lower;
	logic [23:0] next_pin_direction;
	logic [23:0] next_rising;
	logic [23:0] next_falling;
	logic [23:0] next_flags;
	logic [7:0]  next_rdata;
	logic [23:0] pin_sync;
	logic [23:0] pin_prev;
	logic [23:0] is_gpio_in;
	logic [23:0] edge_hit;
	logic [23:0] clear_mask;
	logic [47:0] func_all;
	logic        any_pending;
	logic        pending_prev;
	logic [7:0]  pulse_cnt;
	logic [7:0]  next_pulse_cnt;
	logic        next_int_req;
	gpaf_pkg::gpaf_mode_t mode;
	gpaf_pkg::gpaf_mode_t next_mode;

	// Both modes run the same clocked path, so nothing changes for wake in sleep
	gpaf_sync #(.WIDTH(NPINS)) u_sync (
		.CLK      (CLK),
		.RST      (RST),
		.async_in (PIN_IN),
		.sync_out (pin_sync)
	);

	assign func_all = {func_upper, func_lower};

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			PIN_FUNC[2*i +: 2] = func_all[2*i +: 2];
			is_gpio_in[i] = (func_all[2*i +: 2] == `GPAF_CODE_PRIMARY) && !pin_direction[i];
			case (func_all[2*i +: 2])
				`GPAF_CODE_ALT1: begin
					PIN_OUT[i] = ALT1_OUT[i];
					PIN_OE[i]  = 1'b1;
				end
				`GPAF_CODE_ALT2: begin
					PIN_OUT[i] = ALT2_OUT[i];
					PIN_OE[i]  = 1'b1;
				end
				`GPAF_CODE_ALT3: begin
					PIN_OUT[i] = ALT3_OUT[i];
					PIN_OE[i]  = 1'b1;
				end
				default: begin
					PIN_OUT[i] = GPIO_OUT_VAL[i] | PRIM_OUT[i];
					PIN_OE[i]  = pin_direction[i];
				end
			endcase
		end
	end

	assign GPIO_IN_VAL = pin_sync;
	assign EDGE_FLAGS  = edge_detect_flags;
	assign ASLEEP      = (mode == gpaf_pkg::GPAF_SLEEP);

	// ****************************************
	// Register writes and edge flags
	// ****************************************
	always_comb begin
		next_func_upper    = func_upper;
		next_func_lower    = func_lower;
		next_pin_direction = pin_direction;
		next_rising        = rising_edge_enable;
		next_falling       = falling_edge_enable;
		clear_mask         = `GPAF_RESET_PINS;
		if (BUS.wr) begin
			case (BUS.addr)
				`GPAF_ADDR_FU_HIGH:  next_func_upper = put_byte(func_upper, 2'h2, BUS.wdata);
				`GPAF_ADDR_FU_MID:   next_func_upper = put_byte(func_upper, 2'h1, BUS.wdata);
				`GPAF_ADDR_FU_LOW:   next_func_upper = put_byte(func_upper, 2'h0, BUS.wdata);
				`GPAF_ADDR_FL_HIGH:  next_func_lower = put_byte(func_lower, 2'h2, BUS.wdata);
				`GPAF_ADDR_FL_MID:   next_func_lower = put_byte(func_lower, 2'h1, BUS.wdata);
				`GPAF_ADDR_FL_LOW:   next_func_lower = put_byte(func_lower, 2'h0, BUS.wdata);
				`GPAF_ADDR_DIR_MSB:  next_pin_direction = put_byte(pin_direction, 2'h2, BUS.wdata);
				`GPAF_ADDR_DIR_CSB:  next_pin_direction = put_byte(pin_direction, 2'h1, BUS.wdata);
				`GPAF_ADDR_DIR_LSB:  next_pin_direction = put_byte(pin_direction, 2'h0, BUS.wdata);
				`GPAF_ADDR_RISE_MSB: next_rising = put_byte(rising_edge_enable, 2'h2, BUS.wdata);
				`GPAF_ADDR_RISE_CSB: next_rising = put_byte(rising_edge_enable, 2'h1, BUS.wdata);
				`GPAF_ADDR_RISE_LSB: next_rising = put_byte(rising_edge_enable, 2'h0, BUS.wdata);
				`GPAF_ADDR_FALL_MSB: next_falling = put_byte(falling_edge_enable, 2'h2, BUS.wdata);
				`GPAF_ADDR_FALL_CSB: next_falling = put_byte(falling_edge_enable, 2'h1, BUS.wdata);
				`GPAF_ADDR_FALL_LSB: next_falling = put_byte(falling_edge_enable, 2'h0, BUS.wdata);
				`GPAF_ADDR_EDGE_MSB: clear_mask = put_byte(`GPAF_RESET_PINS, 2'h2, BUS.wdata);
				`GPAF_ADDR_EDGE_CSB: clear_mask = put_byte(`GPAF_RESET_PINS, 2'h1, BUS.wdata);
				`GPAF_ADDR_EDGE_LSB: clear_mask = put_byte(`GPAF_RESET_PINS, 2'h0, BUS.wdata);
				default: begin
				end
			endcase
		end
		edge_hit = is_gpio_in & ((rising_edge_enable & pin_sync & ~pin_prev) |
			   (falling_edge_enable & ~pin_sync & pin_prev));
		// Set beats clear so an edge in the clearing cycle survives
		next_flags = (edge_detect_flags & ~clear_mask) | edge_hit;
	end

	always_comb begin
		next_rdata = `GPAF_RESET_BYTE;
		if (BUS.rd) begin
			case (BUS.addr)
				`GPAF_ADDR_FU_HIGH:  next_rdata = get_byte(func_upper, 2'h2);
				`GPAF_ADDR_FU_MID:   next_rdata = get_byte(func_upper, 2'h1);
				`GPAF_ADDR_FU_LOW:   next_rdata = get_byte(func_upper, 2'h0);
				`GPAF_ADDR_FL_HIGH:  next_rdata = get_byte(func_lower, 2'h2);
				`GPAF_ADDR_FL_MID:   next_rdata = get_byte(func_lower, 2'h1);
				`GPAF_ADDR_FL_LOW:   next_rdata = get_byte(func_lower, 2'h0);
				`GPAF_ADDR_DIR_MSB:  next_rdata = get_byte(pin_direction, 2'h2);
				`GPAF_ADDR_DIR_CSB:  next_rdata = get_byte(pin_direction, 2'h1);
				`GPAF_ADDR_DIR_LSB:  next_rdata = get_byte(pin_direction, 2'h0);
				`GPAF_ADDR_EDGE_MSB: next_rdata = get_byte(edge_detect_flags, 2'h2);
				`GPAF_ADDR_EDGE_CSB: next_rdata = get_byte(edge_detect_flags, 2'h1);
				`GPAF_ADDR_EDGE_LSB: next_rdata = get_byte(edge_detect_flags, 2'h0);
				`GPAF_ADDR_RISE_MSB: next_rdata = get_byte(rising_edge_enable, 2'h2);
				`GPAF_ADDR_RISE_CSB: next_rdata = get_byte(rising_edge_enable, 2'h1);
				`GPAF_ADDR_RISE_LSB: next_rdata = get_byte(rising_edge_enable, 2'h0);
				`GPAF_ADDR_FALL_MSB: next_rdata = get_byte(falling_edge_enable, 2'h2);
				`GPAF_ADDR_FALL_CSB: next_rdata = get_byte(falling_edge_enable, 2'h1);
				`GPAF_ADDR_FALL_LSB: next_rdata = get_byte(falling_edge_enable, 2'h0);
				default:             next_rdata = `GPAF_RESET_BYTE;
			endcase
		end else begin
			next_rdata = RDATA;
		end
	end

	// ****************************************
	// Interrupt, wake and sleep
	// ****************************************
	always_comb begin
		any_pending    = GLOBAL_INT_EN && |(edge_detect_flags & PIN_INT_EN & is_gpio_in);
		next_pulse_cnt = (pulse_cnt != 8'h00) ? pulse_cnt - 8'h01 : 8'h00;
		if (INT_EDGE_MODE && any_pending && !pending_prev) begin
			next_pulse_cnt = 8'(PW);
		end
		next_int_req = INT_EDGE_MODE ? (next_pulse_cnt != 8'h00) : any_pending;
		WAKE         = any_pending && (mode == gpaf_pkg::GPAF_SLEEP);
		case (mode)
			gpaf_pkg::GPAF_RUN:   next_mode = SLEEP_REQ ? gpaf_pkg::GPAF_SLEEP : gpaf_pkg::GPAF_RUN;
			gpaf_pkg::GPAF_SLEEP: next_mode = any_pending ? gpaf_pkg::GPAF_RUN : gpaf_pkg::GPAF_SLEEP;
			default:              next_mode = gpaf_pkg::GPAF_RUN;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			func_upper          <= `GPAF_RESET_PINS;
			func_lower          <= `GPAF_RESET_PINS;
			pin_direction       <= `GPAF_RESET_PINS;
			rising_edge_enable  <= `GPAF_RESET_PINS;
			falling_edge_enable <= `GPAF_RESET_PINS;
			edge_detect_flags   <= `GPAF_RESET_PINS;
			pin_prev            <= `GPAF_RESET_PINS;
			RDATA               <= `GPAF_RESET_BYTE;
			pending_prev        <= 1'b0;
			pulse_cnt           <= 8'h00;
			INT_REQ             <= 1'b0;
			mode                <= gpaf_pkg::GPAF_RUN;
		end else begin
			func_upper          <= next_func_upper;
			func_lower          <= next_func_lower;
			pin_direction       <= next_pin_direction;
			rising_edge_enable  <= next_rising;
			falling_edge_enable <= next_falling;
			edge_detect_flags   <= next_flags;
			pin_prev            <= pin_sync;
			RDATA               <= next_rdata;
			pending_prev        <= any_pending;
			pulse_cnt           <= next_pulse_cnt;
			INT_REQ             <= next_int_req;
			mode                <= next_mode;
		end
	end
endmodule : gpaf_hotkey

// >>> testbench/gpaf_hotkey_asserts.sv
// Checker for the pin function and wake block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module gpaf_hotkey_asserts #(
	parameter int NPINS = 24
) (
	input wire logic                CLK,
	input wire logic                RST,
	input wire gpaf_pkg::gpaf_bus_t BUS,
	input wire logic [7:0]          RDATA,
	input wire logic                GLOBAL_INT_EN,
	input wire logic                INT_EDGE_MODE,
	input wire logic [NPINS-1:0]    PIN_IN,
	input wire logic [NPINS-1:0]    ALT1_OUT,
	input wire logic [NPINS-1:0]    PIN_OUT,
	input wire logic [NPINS-1:0]    PIN_OE,
	input wire logic [NPINS-1:0]    GPIO_IN_VAL,
	input wire logic [2*NPINS-1:0]  PIN_FUNC,
	input wire logic [NPINS-1:0]    EDGE_FLAGS,
	input wire logic                ASLEEP,
	input wire logic                WAKE,
	input wire logic                INT_REQ
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	a_func_top: assert property (BUS.wr && BUS.addr == 8'h9B |=> PIN_FUNC[47:40] == $past(BUS.wdata))
		else $error("upper high byte not in pins 23 to 20");
	a_func_bottom: assert property (BUS.wr && BUS.addr == 8'hA0 |=> PIN_FUNC[7:0] == $past(BUS.wdata))
		else $error("lower low byte not in pins 3 to 0");
	a_read_back: assert property (BUS.rd && BUS.addr == 8'h9D |=> ##1 RDATA == $past(PIN_FUNC[31:24], 2))
		else $error("function field read back wrong");
	a_alt_drive: assert property (PIN_FUNC[1:0] != 2'h0 |-> PIN_OE[0])
		else $error("alternate code not driving pin");
	a_alt1_route: assert property (PIN_FUNC[1:0] == 2'h1 |-> PIN_OUT[0] == ALT1_OUT[0])
		else $error("code 01 not routed to alternate 1");
	a_mask_quiet: assert property ((!GLOBAL_INT_EN && !INT_EDGE_MODE) [*2] |=> !INT_REQ)
		else $error("interrupt with global mask off");
	a_int_cause: assert property ($rose(INT_REQ) |-> $past(GLOBAL_INT_EN) && $past(|EDGE_FLAGS))
		else $error("interrupt without edge flag");
	// Ten high cycles split in two runs of five to keep the repetition short
	a_pulse_width: assert property ($rose(INT_REQ) && INT_EDGE_MODE |-> INT_REQ [*5] ##1 INT_REQ [*5] ##1 !INT_REQ)
		else $error("edge interrupt pulse not 10 cycles");
	a_wake_exit: assert property (WAKE |-> ##[1:4] !ASLEEP)
		else $error("wake did not leave sleep");
	a_flag_keep: assert property (BUS.wr && BUS.addr == 8'h8E && !BUS.wdata[0] && EDGE_FLAGS[0] |=> EDGE_FLAGS[0])
		else $error("writing 0 cleared edge flag");
	a_sync_follow: assert property ($stable(PIN_IN) [*8] |-> GPIO_IN_VAL == PIN_IN)
		else $error("synchronised input lags too long");
	c_pulse: cover property ($rose(INT_REQ) && INT_EDGE_MODE);
	c_wake: cover property (WAKE);
	c_unmapped: cover property (BUS.rd && BUS.addr == 8'hA5);
endmodule : gpaf_hotkey_asserts
bind gpaf_hotkey gpaf_hotkey_asserts #(.NPINS(NPINS)) i_gpaf_hotkey_asserts (.CLK(CLK), .RST(RST), .BUS(BUS),
	.RDATA(RDATA), .GLOBAL_INT_EN(GLOBAL_INT_EN), .INT_EDGE_MODE(INT_EDGE_MODE), .PIN_IN(PIN_IN),
	.ALT1_OUT(ALT1_OUT), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .GPIO_IN_VAL(GPIO_IN_VAL), .PIN_FUNC(PIN_FUNC),
	.EDGE_FLAGS(EDGE_FLAGS), .ASLEEP(ASLEEP), .WAKE(WAKE), .INT_REQ(INT_REQ));

// >>> testbench/gpaf_host_model.sv
// Host side model: byte register writes and reads.
// Assumes the bench calls its tasks; requests change at the falling edge.
`timescale 1ns/1ps
module gpaf_host_model (
	input wire logic            CLK,
	input wire logic [7:0]      RDATA,
	output gpaf_pkg::gpaf_bus_t BUS
);
	initial BUS = '0;
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		BUS.wr = 1'b1;
		BUS.addr = a;
		BUS.wdata = d;
		@(negedge CLK);
		BUS.wr = 1'b0;
		// Released data toggles so nothing relies on stale values
		BUS.wdata = ~d;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge CLK);
		BUS.rd = 1'b1;
		BUS.addr = a;
		@(negedge CLK);
		BUS.rd = 1'b0;
		@(negedge CLK);
		d = RDATA;
	endtask : read
endmodule : gpaf_host_model

// >>> testbench/tb_top.sv
// Self-checking bench for the pin function and wake block.
// Assumes the host model drives the bus; pins and masks come from here.
`timescale 1ns/1ps
module tb_top;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	gpaf_pkg::gpaf_bus_t bus;
	logic [7:0]          rdata;
	logic                glob_en = 1'b0;
	logic [23:0]         pin_en = 24'h000000;
	logic                edge_mode = 1'b0;
	logic                sleep_req = 1'b0;
	logic [23:0]         pin_in = 24'h000000;
	logic [23:0]         alt1 = 24'hFFFFFF;
	logic [23:0]         alt3 = 24'hFFFFFF;
	logic [23:0]         pin_out, pin_oe, gpio_in, flags;
	logic [47:0]         pin_func;
	logic                asleep, wake, int_req;
	int                  n_mismatch = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	always #12.5 clk = ~clk;
	gpaf_host_model i_gpaf_host_model (.CLK(clk), .RDATA(rdata), .BUS(bus));
	gpaf_hotkey #(.NPINS(24)) i_gpaf_hotkey (.CLK(clk), .RST(rst), .BUS(bus), .RDATA(rdata), .GLOBAL_INT_EN(glob_en),
		.PIN_INT_EN(pin_en), .INT_EDGE_MODE(edge_mode), .SLEEP_REQ(sleep_req), .PIN_IN(pin_in),
		.GPIO_OUT_VAL(24'h000000), .ALT1_OUT(alt1), .ALT2_OUT(24'h000000), .ALT3_OUT(alt3), .PRIM_OUT(24'h000000),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .GPIO_IN_VAL(gpio_in), .PIN_FUNC(pin_func), .EDGE_FLAGS(flags),
		.ASLEEP(asleep), .WAKE(wake), .INT_REQ(int_req));
	task automatic summarize;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_gpaf_host_model.write(a, d);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_gpaf_host_model.read(a, v);
		chk(48'(v), 48'(e));
	endtask : rd_chk
	task automatic pulse_pin(input bit expect_int);
		int k = 0;
		pin_in[0] = 1'b1;
		while (int_req !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk(48'(int_req), 48'(expect_int));
	endtask : pulse_pin
	task automatic t_map;
		logic [7:0] v[6] = '{8'hC0, 8'h1B, 8'h2D, 8'h39, 8'h4E, 8'h01};
		for (int i = 0; i < 6; i++) rd_chk(8'h9B + 8'(i), 8'h00);
		for (int i = 0; i < 6; i++) wr(8'h9B + 8'(i), v[i]);
		for (int i = 0; i < 6; i++) rd_chk(8'h9B + 8'(i), v[i]);
		wr(8'hA5, 8'hFF);
		rd_chk(8'hA5, 8'h00);
		chk(pin_func, {v[0], v[1], v[2], v[3], v[4], v[5]});
		for (int i = 0; i < 6; i++) wr(8'h9B + 8'(i), 8'h00);
		$display("test map done");
	endtask : t_map
	task automatic t_codes;
		for (int c = 1; c < 4; c++) begin
			wr(8'hA0, 8'(c));
			chk(48'(pin_oe[0]), 48'h1);
			chk(48'(pin_out[0]), 48'(c != 2));
		end
		wr(8'hA0, 8'h00);
		chk(48'(pin_oe[0]), 48'h0);
		wr(8'h8B, 8'h01);
		chk(48'(pin_oe[0]), 48'h1);
		$display("test codes done");
	endtask : t_codes
	task automatic t_wake;
		wr(8'hA0, 8'h00);
		wr(8'h8B, 8'h00);
		wr(8'h91, 8'h01);
		pin_en = 24'h000001;
		glob_en = 1'b1;
		sleep_req = 1'b1;
		@(negedge clk);
		sleep_req = 1'b0;
		@(negedge clk);
		chk(48'(asleep), 48'h1);
		pulse_pin(1'b1);
		repeat (4) @(negedge clk);
		chk(48'(asleep), 48'h0);
		repeat (2500) @(negedge clk);
		pin_in[0] = 1'b0;
		wr(8'h8E, 8'h00);
		chk(48'(flags[0]), 48'h1);
		wr(8'h8E, 8'h01);
		@(negedge clk);
		chk(48'(flags[0]), 48'h0);
		$display("test wake done");
	endtask : t_wake
	task automatic t_mask;
		glob_en = 1'b0;
		pulse_pin(1'b0);
		chk(48'(flags[0]), 48'h1);
		repeat (2500) @(negedge clk);
		pin_in[0] = 1'b0;
		wr(8'h8E, 8'h01);
		glob_en = 1'b1;
		edge_mode = 1'b1;
		$display("test mask done");
	endtask : t_mask
	task automatic t_pulse;
		int n = 0;
		pulse_pin(1'b1);
		while (int_req === 1'b1 && n < 30) begin
			@(negedge clk);
			n++;
		end
		chk(48'(n), 48'd10);
		repeat (2500) @(negedge clk);
		pin_in[0] = 1'b0;
		wr(8'h8E, 8'h01);
		$display("test pulse done");
	endtask : t_pulse
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_map();
		t_codes();
		t_wake();
		t_mask();
		t_pulse();
		summarize();
	end
endmodule : tb_top
